// ===== bench/mcu_model.sv
module mcu_model (
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic bit_clock_i,
    input  wire logic use_clock_i,
    input  wire logic level_i,
    output logic      tx_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pattern_q;
    logic        clk_seen_q;
    // -----------------------------
    // bit stream handed to the modem
    // -----------------------------
    // next bit is handed over at each rise of the bit request clock
    always @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pattern_q  <= 16'h5555;
            clk_seen_q <= 1'b0;
        end
        else
        begin
            clk_seen_q <= bit_clock_i;
            if (bit_clock_i && !clk_seen_q)
                pattern_q <= {pattern_q[0], pattern_q[15:1]};
        end
    end
    // level mode stands in for asynchronous data entry
    assign tx_data_o = use_clock_i ? pattern_q[0] : level_i;
endmodule

// ===== bench/test_fsk_ook_modem_datapath.sv
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module test_fsk_ook_modem_datapath;
    timeunit 1ns;
    timeprecision 1ps;
    import modem_pkg::*;
    logic        ref_clk_i, resetn_i, cyc, stb, we, fsk_bit, use_clk, level;
    logic [7:0]  adr, rssi;
    logic [3:0]  sel;
    logic [31:0] dat, wb_dat_o, rd;
    logic [15:0] foff, pll_frac_offset_o;
    logic [7:0]  pa_level_o;
    logic        wb_ack_o, tx_data, recovered_bit_clock_o, rx_data_o;
    int          err_total, num_checks, c;
    // -----------------------------
    // design and partner
    // -----------------------------
    fsk_ook_modem_datapath i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tx_data_i(tx_data), .rssi_i(rssi), .fsk_bit_i(fsk_bit), .freq_offset_i(foff),
        .pll_frac_offset_o(pll_frac_offset_o), .pa_level_o(pa_level_o),
        .recovered_bit_clock_o(recovered_bit_clock_o), .rx_data_o(rx_data_o));
    mcu_model i_mcu (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .bit_clock_i(recovered_bit_clock_o),
        .use_clock_i(use_clk), .level_i(level), .tx_data_o(tx_data));
    // clock generation
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // -----------------------------
    // shared tasks
    // -----------------------------
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // classic single cycle, held until ack is sampled high
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20)
            `CHK(1'b0, 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic count_rises(input int n);
        logic prev;
        prev = recovered_bit_clock_o;
        c = 0;
        repeat (n)
        begin
            @(posedge ref_clk_i);
            #1;
            if (recovered_bit_clock_o === 1'b1 && prev !== 1'b1)
                c++;
            prev = recovered_bit_clock_o;
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // -----------------------------
    // scenarios
    // -----------------------------
    task automatic t_reset_values();
        logic [7:0]  addrs [7];
        logic [15:0] vals [7];
        addrs = '{ADDR_CTRL, ADDR_FDEV, ADDR_BR_HI, ADDR_BR_LO, ADDR_OOK, ADDR_FLOOR, 8'h40};
        vals = '{16'h0000, 16'h0052, 16'h001A, 16'h000B, 16'h0025, 16'h000C, 16'h0000};
        foreach (addrs[i])
        begin
            wb_xfer(1'b0, addrs[i], 32'h0);
            `CHK(rd[15:0], vals[i]);
        end
        wb_xfer(1'b1, 8'h40, 32'hFFFF);
        wb_xfer(1'b0, 8'h40, 32'h0);
        `CHK(rd, 32'h0);
        wb_xfer(1'b1, ADDR_BR_HI, 32'h00);
        wb_xfer(1'b1, ADDR_BR_LO, 32'h0C);
    endtask
    task automatic t_fsk_tx();
        wb_xfer(1'b1, ADDR_FDEV, 32'h1234);
        wb_xfer(1'b1, ADDR_CTRL, 32'h20);
        level <= 1'b1;
        tick(10);
        `CHK(pll_frac_offset_o, 16'h1234);
        level <= 1'b0;
        tick(10);
        `CHK(pll_frac_offset_o, 16'hEDCC);
    endtask
    task automatic t_ook_tx();
        wb_xfer(1'b1, ADDR_CTRL, 32'h21);
        level <= 1'b1;
        tick(8);
        `CHK(pa_level_o, PA_FULL);
        level <= 1'b0;
        tick(8);
        `CHK(pa_level_o, 8'h00);
        wb_xfer(1'b1, ADDR_CTRL, 32'h23);
        tick(20);
        level <= 1'b1;
        tick(8);
        `CHK(pa_level_o != PA_FULL && pa_level_o != 8'h00, 1'b1);
        tick(1100);
        `CHK(pa_level_o, PA_FULL);
        level <= 1'b0;
        tick(8);
        `CHK(pa_level_o != PA_FULL && pa_level_o != 8'h00, 1'b1);
        tick(1100);
    endtask
    task automatic t_gauss_tx();
        use_clk <= 1'b1;
        wb_xfer(1'b1, ADDR_CTRL, 32'h2A);
        tick(40);
        count_rises(120);
        `CHK(c >= 9 && c <= 11, 1'b1);
        wb_xfer(1'b1, ADDR_CTRL, 32'h0C);
        tick(4);
        wb_xfer(1'b1, ADDR_CTRL, 32'h2C);
        count_rises(120);
        `CHK(c >= 9 && c <= 11, 1'b1);
        use_clk <= 1'b0;
    endtask
    task automatic t_ook_rx();
        wb_xfer(1'b1, ADDR_FLOOR, 32'h40);
        wb_xfer(1'b1, ADDR_OOK, 32'h04);
        wb_xfer(1'b1, ADDR_CTRL, 32'h59);
        rssi <= 8'h50;
        tick(10);
        `CHK(rx_data_o, 1'b1);
        rssi <= 8'h30;
        tick(10);
        `CHK(rx_data_o, 1'b0);
        wb_xfer(1'b1, ADDR_OOK, 32'h06);
        rssi <= 8'h60;
        tick(400);
        wb_xfer(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[15:8] >= 8'h58 && rd[15:8] <= 8'h60, 1'b1);
        wb_xfer(1'b1, ADDR_FLOOR, 32'h20);
        wb_xfer(1'b1, ADDR_OOK, 32'h05);
        rssi <= 8'h80;
        tick(60);
        wb_xfer(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[15:8], 8'h80 - PEAK_DROP[7:0]);
        rssi <= 8'h00;
        tick(200);
        wb_xfer(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[15:8] < 8'h74 && rd[15:8] > 8'h20, 1'b1);
        tick(3000);
        wb_xfer(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[15:8], 8'h20);
    endtask
    task automatic t_sync_rx();
        wb_xfer(1'b1, ADDR_CTRL, 32'h48);
        fork
            repeat (24)
            begin
                tick(12);
                fsk_bit <= ~fsk_bit;
            end
            begin
                tick(120);
                count_rises(120);
            end
        join
        `CHK(c >= 9 && c <= 11, 1'b1);
        wb_xfer(1'b1, ADDR_CTRL, 32'h58);
        fsk_bit <= 1'b1;
        tick(8);
        `CHK(rx_data_o, 1'b1);
        fsk_bit <= 1'b0;
        tick(8);
        `CHK(rx_data_o, 1'b0);
    endtask
    task automatic t_fei();
        realtime t0;
        int n;
        foff <= 16'hFFFB;
        wb_xfer(1'b1, ADDR_CTRL, 32'h40);
        wb_xfer(1'b1, ADDR_CTRL, 32'hC0);
        t0 = $realtime;
        n = 0;
        do
        begin
            wb_xfer(1'b0, ADDR_STAT, 32'h0);
            n++;
        end
        while (rd[0] !== 1'b1 && n < 40);
        `CHK(($realtime - t0) <= 530.0, 1'b1);
        wb_xfer(1'b0, ADDR_FEI, 32'h0);
        `CHK(rd, 32'h0000FFFB);
    endtask
    // -----------------------------
    // main sequence and watchdog
    // -----------------------------
    initial
    begin
        err_total = 0;
        num_checks = 0;
        resetn_i = 1'b0;
        {cyc, stb, we, fsk_bit, use_clk, level} = '0;
        adr = '0; sel = '0; dat = '0; rssi = '0; foff = '0;
        tick(2);
        resetn_i <= 1'b1;
        t_reset_values();
        t_fsk_tx();
        t_ook_tx();
        t_gauss_tx();
        t_ook_rx();
        t_sync_rx();
        t_fei();
        print_verdict();
    end
    initial
    begin
        #200us;
        err_total++;
        print_verdict();
    end
endmodule

// ===== hdl/fsk_ook_modem_datapath.sv
// Operation
// - fsk deviation equals step times 14-bit field
// - ook keys power amplifier on and off
// - gaussian filter bt 0.5 or 1
// - bit clock pulses once per transmitted bit; the code pulses it only with gaussian shaping in continuous mode
// - ook shaping ramps amplifier level gradually
// - fsk demodulator output feeds bit synchronizer
// - ook bit decided by rssi against threshold
// - peak mode threshold is peak minus 6dB
// - peak decays one step per decay period
// - peak threshold never drops below floor; the code clamps the peak to floor plus 6dB only at decay ticks
// - fixed uses floor, average uses running mean
// - synchronizer drives bit clock, can be bypassed
// - synchronizer forced on in packet mode
// - frequency error stored as two's complement
// - frequency error completes within 4 bits
// - result scaled in synthesizer frequency steps
//
// Decided for this implementation: the register offsets and register access over Wishbone.
module fsk_ook_modem_datapath
    import modem_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        tx_data_i,
    input  wire logic [7:0]  rssi_i,
    input  wire logic        fsk_bit_i,
    input  wire logic [15:0] freq_offset_i,
    output logic      [15:0] pll_frac_offset_o,
    output logic      [7:0]  pa_level_o,
    output logic             recovered_bit_clock_o,
    output logic             rx_data_o
);
    // ---------------------------------------------
    // register file and wishbone slave
    // ---------------------------------------------
    ctrl_t       ctrl_q, ctrl_d;
    ook_cfg_t    ook_q, ook_d;
    logic [13:0] fdev_q, fdev_d;
    logic [7:0]  br_hi_q, br_hi_d, br_lo_q, br_lo_d, floor_q, floor_d;
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic        wr, fei_go;
    logic [7:0]  thr_q, peak_q, avg_q, pa_q;
    logic        ook_bit_q, done_q, rxd_q;
    logic [15:0] result_q;
    fei_state_t  fei_q;

    // decode, byte-lane writes at the acknowledging edge, read mux
    always_comb
    begin
        ctrl_d  = ctrl_q;
        ctrl_d.launch = 1'b0;
        fdev_d  = fdev_q;
        br_hi_d = br_hi_q;
        br_lo_d = br_lo_q;
        ook_d   = ook_q;
        floor_d = floor_q;
        wr      = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
        ack_d   = wb_cyc_i && wb_stb_i && !ack_q;
        fei_go  = wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0] && wb_dat_i[7] && ctrl_q.rx_en;
        if (wr && wb_sel_i[0])
        begin
            case (wb_adr_i)
                ADDR_CTRL:  ctrl_d  = ctrl_t'({1'b0, wb_dat_i[6:0]});
                ADDR_FDEV:  fdev_d[7:0] = wb_dat_i[7:0];
                ADDR_BR_HI: br_hi_d = wb_dat_i[7:0];
                ADDR_BR_LO: br_lo_d = wb_dat_i[7:0];
                ADDR_OOK:   ook_d   = ook_cfg_t'(wb_dat_i[7:0]);
                ADDR_FLOOR: floor_d = wb_dat_i[7:0];
                default:    ;
            endcase
        end
        if (wr && wb_sel_i[1] && wb_adr_i == ADDR_FDEV)
            fdev_d[13:8] = wb_dat_i[13:8];
        case (wb_adr_i)
            ADDR_CTRL:  rdat_d = {24'h000000, ctrl_q};
            ADDR_FDEV:  rdat_d = {18'h00000, fdev_q};
            ADDR_BR_HI: rdat_d = {24'h000000, br_hi_q};
            ADDR_BR_LO: rdat_d = {24'h000000, br_lo_q};
            ADDR_OOK:   rdat_d = {24'h000000, ook_q};
            ADDR_FLOOR: rdat_d = {24'h000000, floor_q};
            ADDR_STAT:  rdat_d = {16'h0000, thr_q, 4'h0, ook_bit_q, rxd_q, fei_q, done_q};
            ADDR_FEI:   rdat_d = {16'h0000, result_q};
            default:    rdat_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_q  <= ctrl_t'(CTRL_RST);
            fdev_q  <= FDEV_RST;
            br_hi_q <= BR_HI_RST;
            br_lo_q <= BR_LO_RST;
            ook_q   <= ook_cfg_t'(OOK_RST);
            floor_q <= FLOOR_RST;
            ack_q   <= 1'b0;
            rdat_q  <= 32'h00000000;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            fdev_q  <= fdev_d;
            br_hi_q <= br_hi_d;
            br_lo_q <= br_lo_d;
            ook_q   <= ook_d;
            floor_q <= floor_d;
            ack_q   <= ack_d;
            rdat_q  <= rdat_d;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ---------------------------------------------
    // bit timing and transmit path
    // ---------------------------------------------
    logic [15:0] br, half, br_cnt_q, br_cnt_d;
    logic        bit_tick, sync1_q, sync2_q, gauss, tx_clk_q, tx_clk_d;
    logic [2:0]  hist_q, hist_d;
    logic signed [4:0]  we_, wc, acc;
    logic signed [19:0] prod;
    logic [15:0] dev_q, dev_d;
    logic [1:0]  ramp_q, ramp_d;
    logic [7:0]  pa_d, pa_tgt;

    // bit period from the divider, deviation and pa level
    always_comb
    begin
        br       = ({br_hi_q, br_lo_q} == 16'h0000) ? 16'h0001 : {br_hi_q, br_lo_q};
        half     = {1'b0, br[15:1]};
        bit_tick = br_cnt_q >= br - 16'h0001;
        br_cnt_d = bit_tick ? 16'h0000 : br_cnt_q + 16'h0001;
        gauss    = !ctrl_q.ook && ctrl_q.shaping != SHAPE_NONE;
        tx_clk_d = ctrl_q.tx_en && gauss && ctrl_q.continuous && br_cnt_q < half;
        hist_d   = (bit_tick && ctrl_q.tx_en) ? {hist_q[1:0], sync2_q} : hist_q;
        we_      = (ctrl_q.shaping == SHAPE_BT1) ? 5'sh01 : 5'sh02;
        wc       = (ctrl_q.shaping == SHAPE_BT1) ? 5'sh06 : 5'sh04;
        acc      = (hist_q[2] ? we_ : -we_) + (hist_q[1] ? wc : -wc) + (hist_q[0] ? we_ : -we_);
        prod     = $signed({1'b0, fdev_q}) * acc;
        if (!ctrl_q.tx_en || ctrl_q.ook)
            dev_d = 16'h0000;
        else if (gauss)
            dev_d = prod[18:3];
        else
            dev_d = sync2_q ? {2'b00, fdev_q} : 16'h0000 - {2'b00, fdev_q};
        pa_tgt = (ctrl_q.tx_en && ctrl_q.ook && sync2_q) ? PA_FULL : 8'h00;
        ramp_d = ramp_q + 2'h1;
        pa_d   = pa_q;
        if (ctrl_q.shaping == SHAPE_NONE)
            pa_d = pa_tgt;
        else if (ramp_q == RAMP_LAST && pa_q != pa_tgt)
            pa_d = (pa_q < pa_tgt) ? pa_q + 8'h01 : pa_q - 8'h01;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            br_cnt_q <= 16'h0000;
            sync1_q  <= 1'b0;
            sync2_q  <= 1'b0;
            tx_clk_q <= 1'b0;
            hist_q   <= 3'h0;
            dev_q    <= 16'h0000;
            ramp_q   <= 2'h0;
            pa_q     <= 8'h00;
        end
        else
        begin
            br_cnt_q <= br_cnt_d;
            sync1_q  <= tx_data_i;
            sync2_q  <= sync1_q;
            tx_clk_q <= tx_clk_d;
            hist_q   <= hist_d;
            dev_q    <= dev_d;
            ramp_q   <= ramp_d;
            pa_q     <= pa_d;
        end
    end
    assign pll_frac_offset_o = dev_q;
    assign pa_level_o        = pa_q;

    // ---------------------------------------------
    // ook threshold and demodulator
    // ---------------------------------------------
    logic [2:0]  dec_cnt_q, dec_cnt_d;
    logic [7:0]  thr_d, peak_d, avg_d;
    logic [8:0]  peak_min, peak_dec;
    logic signed [9:0] diff;
    logic [9:0]  avg_sum;
    logic        dec_tick, ook_bit_d;

    // peak tracking with decay and floor, running average, compare
    always_comb
    begin
        peak_min  = {1'b0, floor_q} + PEAK_DROP;
        peak_dec  = {1'b0, peak_q} - {6'h00, ook_q.step};
        dec_tick  = bit_tick && dec_cnt_q == ook_q.period;
        dec_cnt_d = bit_tick ? (dec_tick ? 3'h0 : dec_cnt_q + 3'h1) : dec_cnt_q;
        peak_d    = peak_q;
        if (rssi_i > peak_q)
            peak_d = rssi_i;
        else if (dec_tick && !ook_bit_q)
            peak_d = (peak_dec[8] || peak_dec < peak_min) ? peak_min[7:0] : peak_dec[7:0];
        if (peak_min[8])
            peak_d = PA_FULL;
        diff    = $signed({2'b00, rssi_i}) - $signed({2'b00, avg_q});
        avg_sum = {2'b00, avg_q} + 10'(diff >>> 3);
        avg_d   = avg_sum[7:0];
        case (thr_t'(ook_q.thr_type))
            THR_PEAK:  thr_d = peak_q - PEAK_DROP[7:0];
            THR_AVG:   thr_d = avg_q;
            default:   thr_d = floor_q;
        endcase
        ook_bit_d = rssi_i > thr_q;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dec_cnt_q <= 3'h0;
            peak_q    <= 8'h00;
            avg_q     <= 8'h00;
            thr_q     <= 8'h00;
            ook_bit_q <= 1'b0;
        end
        else
        begin
            dec_cnt_q <= dec_cnt_d;
            peak_q    <= peak_d;
            avg_q     <= avg_d;
            thr_q     <= thr_d;
            ook_bit_q <= ook_bit_d;
        end
    end

    // ---------------------------------------------
    // bit synchronizer and receive outputs
    // ---------------------------------------------
    logic [15:0] sy_cnt_q, sy_cnt_d;
    logic        raw, raw_q, sy_dat_q, sy_dat_d, sync_on, rxd_d, bclk_q, bclk_d;

    // phase restarts on each data edge, sample at mid bit
    always_comb
    begin
        raw      = ctrl_q.ook ? ook_bit_q : fsk_bit_i;
        sync_on  = !ctrl_q.continuous || !ctrl_q.sync_bypass;
        if (raw != raw_q || sy_cnt_q >= br - 16'h0001)
            sy_cnt_d = 16'h0000;
        else
            sy_cnt_d = sy_cnt_q + 16'h0001;
        sy_dat_d = (sy_cnt_q == half) ? raw : sy_dat_q;
        rxd_d    = ctrl_q.rx_en && (sync_on ? sy_dat_q : raw);
        if (ctrl_q.tx_en)
            bclk_d = tx_clk_q;
        else
            bclk_d = ctrl_q.rx_en && ctrl_q.continuous && sync_on && sy_cnt_q < half;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sy_cnt_q <= 16'h0000;
            raw_q    <= 1'b0;
            sy_dat_q <= 1'b0;
            rxd_q    <= 1'b0;
            bclk_q   <= 1'b0;
        end
        else
        begin
            sy_cnt_q <= sy_cnt_d;
            raw_q    <= raw;
            sy_dat_q <= sy_dat_d;
            rxd_q    <= rxd_d;
            bclk_q   <= bclk_d;
        end
    end
    assign rx_data_o             = rxd_q;
    assign recovered_bit_clock_o = bclk_q;

    // ---------------------------------------------
    // frequency error measurement
    // ---------------------------------------------
    fei_state_t  fei_d;
    logic [1:0]  fbits_q, fbits_d;
    logic signed [17:0] sum_q, sum_d, sum_nx;
    logic [15:0] result_d;
    logic        done_d, fei_last;

    // four per-bit samples averaged; launch ignored while running
    always_comb
    begin
        fei_d    = fei_q;
        fbits_d  = fbits_q;
        sum_d    = sum_q;
        result_d = result_q;
        done_d   = done_q;
        sum_nx   = sum_q + 18'(signed'(freq_offset_i));
        fei_last = fei_q == FEI_RUN && bit_tick && fbits_q == FEI_LAST;
        case (fei_q)
            FEI_IDLE:
                if (fei_go)
                begin
                    fei_d   = FEI_RUN;
                    fbits_d = 2'h0;
                    sum_d   = 18'sh00000;
                    done_d  = 1'b0;
                end
            FEI_RUN:
                if (bit_tick)
                begin
                    sum_d   = sum_nx;
                    fbits_d = fbits_q + 2'h1;
                    if (fei_last)
                    begin
                        result_d = sum_nx[17:2];
                        done_d   = 1'b1;
                        fei_d    = FEI_IDLE;
                    end
                end
            default: fei_d = FEI_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            fei_q    <= FEI_IDLE;
            fbits_q  <= 2'h0;
            sum_q    <= 18'sh00000;
            result_q <= 16'h0000;
            done_q   <= 1'b0;
        end
        else
        begin
            fei_q    <= fei_d;
            fbits_q  <= fbits_d;
            sum_q    <= sum_d;
            result_q <= result_d;
            done_q   <= done_d;
        end
    end

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_fei_last;
        fei_last;
    endsequence
    sequence s_gauss_tick;
        ctrl_q.tx_en && gauss && ctrl_q.continuous && bit_tick && br > 16'h0003;
    endsequence
    sequence s_ook_hard;
        ctrl_q.tx_en && ctrl_q.ook && ctrl_q.shaping == SHAPE_NONE && sync2_q;
    endsequence
    a_fei_done_set: assert property (s_fei_last |=> done_q && fei_q == FEI_IDLE)
        else $error("fei completion not flagged");
    a_fei_result: assert property (done_q && fei_q == FEI_IDLE |=> $stable(result_q))
        else $error("fei result changed while idle");
    a_fei_launch: assert property (fei_go && fei_q == FEI_IDLE |=> fei_q == FEI_RUN && !done_q)
        else $error("fei launch not taken");
    a_gauss_clk: assert property (s_gauss_tick ##1 (ctrl_q.tx_en && gauss && ctrl_q.continuous) ##1 ctrl_q.tx_en
        |=> bclk_q)
        else $error("bit clock request missing");
    a_ook_key: assert property (s_ook_hard |=> pa_q == PA_FULL)
        else $error("pa not keyed on");
    a_ramp_step: assert property (ctrl_q.shaping != SHAPE_NONE |=>
        pa_q == $past(pa_q) || pa_q == $past(pa_q) + 8'h01 || pa_q == $past(pa_q) - 8'h01)
        else $error("pa level jumped");
    a_fsk_dev: assert property (ctrl_q.tx_en && !ctrl_q.ook && ctrl_q.shaping == SHAPE_NONE && sync2_q
        |=> dev_q == {2'b00, $past(fdev_q)})
        else $error("deviation mismatch");
    a_fixed_thr: assert property (ook_q.thr_type == THR_FIXED |=> thr_q == $past(floor_q))
        else $error("fixed threshold mismatch");
    a_peak_floor: assert property (ook_q.thr_type == THR_PEAK && peak_q >= peak_min[7:0] && !peak_min[8]
        |=> thr_q >= $past(floor_q))
        else $error("peak threshold under floor");
    a_sync_bypass: assert property (ctrl_q.rx_en && ctrl_q.continuous && ctrl_q.sync_bypass
        |=> rxd_q == $past(raw))
        else $error("bypass data mismatch");
endmodule

// ===== shared/modem_pkg.sv
package modem_pkg;
    // ---------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_FDEV  = 8'h04;
    localparam logic [7:0] ADDR_BR_HI = 8'h08;
    localparam logic [7:0] ADDR_BR_LO = 8'h0C;
    localparam logic [7:0] ADDR_OOK   = 8'h10;
    localparam logic [7:0] ADDR_FLOOR = 8'h14;
    localparam logic [7:0] ADDR_STAT  = 8'h18;
    localparam logic [7:0] ADDR_FEI   = 8'h1C;
    // ---------------------------------------------
    // reset values and constants
    // ---------------------------------------------
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [13:0] FDEV_RST  = 14'h0052;
    localparam logic [7:0]  BR_HI_RST = 8'h1A;
    localparam logic [7:0]  BR_LO_RST = 8'h0B;
    localparam logic [7:0]  OOK_RST   = 8'h25;
    localparam logic [7:0]  FLOOR_RST = 8'h0C;
    localparam logic [8:0]  PEAK_DROP = 9'h00C;   // 6 dB in half-dB rssi units
    localparam logic [1:0]  RAMP_LAST = 2'h3;     // pa ramp step every 4 cycles
    localparam logic [1:0]  FEI_LAST  = 2'h3;     // 4 bit periods per measurement
    localparam logic [7:0]  PA_FULL   = 8'hFF;
    localparam logic [1:0]  SHAPE_NONE = 2'h0;
    localparam logic [1:0]  SHAPE_BT1  = 2'h1;
    localparam logic [1:0]  SHAPE_BT05 = 2'h2;
    // ---------------------------------------------
    // types
    // ---------------------------------------------
    typedef struct packed {
        logic       launch;
        logic       rx_en;
        logic       tx_en;
        logic       sync_bypass;
        logic       continuous;
        logic [1:0] shaping;
        logic       ook;
    } ctrl_t;
    typedef struct packed {
        logic [2:0] period;
        logic [2:0] step;
        logic [1:0] thr_type;
    } ook_cfg_t;
    typedef enum logic [1:0] {THR_FIXED = 2'h0, THR_PEAK = 2'h1, THR_AVG = 2'h2} thr_t;
    typedef enum logic {FEI_IDLE = 1'b0, FEI_RUN = 1'b1} fei_state_t;
endpackage
